//--- common/sync_link_if.sv
// Purpose: pins between the host controller and one camera processor
// Assumes: both ends run from the same reference clock
// Notes: all signals are plain levels; no tristate on this link
`timescale 1ns/10ps
interface sync_link_if;
  logic sleep_request;
  logic sync_pulse_in;
  logic out_frame_valid;
  logic out_pixel_clock;

  modport dev (
    input  sleep_request,
    input  sync_pulse_in,
    output out_frame_valid,
    output out_pixel_clock
  );

  modport host (
    output sleep_request,
    output sync_pulse_in,
    input  out_frame_valid,
    input  out_pixel_clock
  );
endinterface : sync_link_if

//--- common/sync_pkg.sv
// Purpose: shared constants and types for the standby and frame sync trigger link
// Assumes: one 10 MHz clock stands in for the reference input clock at both ends
// Notes: line and frame counts are module parameters; fixed figures live here
// Operation
// RULE_01: register write starts a soft reset
// RULE_02: sleep_request high enters standby within 2 frames
// RULE_03: sleep_request low returns to normal operation
// RULE_04: clock runs 10 cycles after sleep assert
// RULE_05: clock runs 10 cycles before sleep release
// RULE_06: host broadcasts one sync pulse to cameras
// RULE_07: each accepted sync pulse forwarded to sensor
// RULE_08: single-shot: one frame per pulse, then stop
// RULE_09: continuous: one pulse starts free-running frames
// RULE_10: frame valid after 8 lines plus exposure, delay
// RULE_11: equal cameras align frame valid within 5 pixclks
// RULE_12: all synced cameras share configuration and exposure
// RULE_13: sleep and sync inputs always driven valid
// RULE_14: sync sampled, rising edge triggers, busy ignores
package sync_pkg;

  localparam int unsigned CLK_PERIOD_NS      = 100;
  // least sync pulse width, in reference clock cycles
  localparam int unsigned SYNC_PULSE_CYCLES  = 3;
  // clock must run this long around each sleep edge
  localparam int unsigned CLK_GUARD_CYCLES   = 10;
  localparam int unsigned TRIG_LEAD_LINES    = 8;
  localparam int unsigned STANDBY_MAX_FRAMES = 2;
  localparam int unsigned LINE_CYCLES_DEF    = 64;
  localparam int unsigned ACTIVE_LINES_DEF   = 16;
  localparam int unsigned BLANK_LINES_DEF    = 4;
  localparam int unsigned LINE_CNT_W         = 12;
  localparam logic [3:0]  PULSE_CNT_RESET    = 4'h0;
  localparam logic [3:0]  GUARD_CNT_RESET    = 4'h0;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'b0_0001,
    ST_DELAY   = 5'b0_0010,
    ST_ACTIVE  = 5'b0_0100,
    ST_BLANK   = 5'b0_1000,
    ST_STANDBY = 5'b1_0000
  } cam_state_t;

endpackage : sync_pkg

//--- hdl/frame_sync_device.sv
// Purpose: camera-side standby control and frame sync trigger
// Assumes: clk is the reference input clock; link pins arrive asynchronously
// Notes: frame timing is counted in clk cycles and lines
`timescale 1ns/10ps
module frame_sync_device
  import sync_pkg::*;
#(
  parameter int unsigned LINE_CYCLES  = LINE_CYCLES_DEF,
  parameter int unsigned ACTIVE_LINES = ACTIVE_LINES_DEF,
  parameter int unsigned BLANK_LINES  = BLANK_LINES_DEF,
  parameter int unsigned LW           = LINE_CNT_W
) (
  input  wire logic          clk,
  input  wire logic          rst_b,
  sync_link_if.dev           link,
  input  wire logic          soft_reset_req,
  input  wire logic          continuous_mode,
  input  wire logic [LW-1:0] exposure_lines,
  input  wire logic [LW-1:0] sensor_delay_lines,
  output logic               sensor_start_out,
  output logic               standby_active,
  output logic               busy
);

  localparam int unsigned CW = $clog2(LINE_CYCLES + 1);
  localparam int unsigned DW = LW + 2;
  localparam logic [CW-1:0] LINE_LAST   = CW'(LINE_CYCLES - 1);
  localparam logic [DW-1:0] ACTIVE_LAST = DW'(ACTIVE_LINES - 1);
  localparam logic [DW-1:0] BLANK_LAST  = DW'(BLANK_LINES - 1);
  localparam logic [DW-1:0] LEAD_LINES  = DW'(TRIG_LEAD_LINES);
  localparam logic [3:0]    PULSE_LOAD  = 4'(SYNC_PULSE_CYCLES);

  // two-stage synchronisers for the link pins
  logic sleep_meta;
  logic sleep_sync;
  logic sync_meta;
  logic sync_sync;
  logic sync_prev;

  cam_state_t    state;
  cam_state_t    next_state;
  logic [CW-1:0] cyc;
  logic [DW-1:0] line_cnt;
  logic [DW-1:0] delay_last;
  logic [3:0]    pulse_cnt;
  logic          trig;
  logic          accept;
  logic          line_tick;
  logic          state_change;
  logic          pix_toggle;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sleep_meta <= 1'b0;
      sleep_sync <= 1'b0;
    end else begin
      sleep_meta <= link.sleep_request;
      sleep_sync <= sleep_meta;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_meta <= 1'b0;
      sync_sync <= 1'b0;
      sync_prev <= 1'b0;
    end else begin
      sync_meta <= link.sync_pulse_in;
      sync_sync <= sync_meta;
      sync_prev <= sync_sync;
    end
  end

  // edge detect on the settled copy, never on the first stage
  assign trig = sync_sync & ~sync_prev; // RULE_14

  // only an idle, awake camera takes a trigger; later pulses are dropped
  assign accept = (state == ST_IDLE) && !sleep_sync && trig && !soft_reset_req; // RULE_14

  assign line_tick    = (cyc == LINE_LAST);
  assign delay_last   = LEAD_LINES + DW'(exposure_lines) + DW'(sensor_delay_lines) - DW'(1); // RULE_10
  assign state_change = (next_state != state);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (sleep_sync) begin
          next_state = ST_STANDBY; // RULE_02
        end else if (accept) begin
          next_state = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (sleep_sync) begin
          next_state = ST_STANDBY; // RULE_02
        end else if (line_tick && line_cnt == delay_last) begin
          next_state = ST_ACTIVE; // RULE_10
        end
      end
      ST_ACTIVE: begin
        // a frame in flight is finished before standby; bounded by one frame
        if (line_tick && line_cnt == ACTIVE_LAST) begin
          if (sleep_sync) begin
            next_state = ST_STANDBY; // RULE_02
          end else if (continuous_mode) begin
            next_state = ST_BLANK; // RULE_09
          end else begin
            next_state = ST_IDLE; // RULE_08
          end
        end
      end
      ST_BLANK: begin
        if (sleep_sync) begin
          next_state = ST_STANDBY; // RULE_02
        end else if (line_tick && line_cnt == BLANK_LAST) begin
          next_state = continuous_mode ? ST_ACTIVE : ST_IDLE; // RULE_09
        end
      end
      ST_STANDBY: begin
        if (!sleep_sync) begin
          next_state = ST_IDLE; // RULE_03
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
    end else if (soft_reset_req) begin
      state <= ST_IDLE; // RULE_01
    end else begin
      state <= next_state;
    end
  end

  // line timer restarts on every state change so latency from the sync
  // edge is a fixed cycle count; equal cameras then line up
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cyc      <= '0;
      line_cnt <= '0;
    end else if (soft_reset_req || state_change) begin
      cyc      <= '0; // RULE_11
      line_cnt <= '0;
    end else if (line_tick) begin
      cyc      <= '0;
      line_cnt <= line_cnt + DW'(1);
    end else begin
      cyc <= cyc + CW'(1);
    end
  end

  // stretched trigger keeps the sensor pulse at least the least sync width
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pulse_cnt <= PULSE_CNT_RESET;
    end else if (soft_reset_req) begin
      pulse_cnt <= PULSE_CNT_RESET; // RULE_01
    end else if (accept) begin
      pulse_cnt <= PULSE_LOAD; // RULE_07
    end else if (pulse_cnt != PULSE_CNT_RESET) begin
      pulse_cnt <= pulse_cnt - 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sensor_start_out <= 1'b0;
    end else if (soft_reset_req) begin
      sensor_start_out <= 1'b0;
    end else begin
      sensor_start_out <= accept || (pulse_cnt > 4'h1); // RULE_07
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      link.out_frame_valid <= 1'b0;
      standby_active       <= 1'b0;
      busy                 <= 1'b0;
    end else if (soft_reset_req) begin
      link.out_frame_valid <= 1'b0;
      standby_active       <= 1'b0;
      busy                 <= 1'b0;
    end else begin
      link.out_frame_valid <= (next_state == ST_ACTIVE); // RULE_10
      standby_active       <= (next_state == ST_STANDBY); // RULE_02
      busy                 <= (next_state != ST_IDLE) && (next_state != ST_STANDBY);
    end
  end

  // pixel clock is clk/2, parked low in standby to save power; keyed on the
  // next state so it is already low on the edge that enters standby
  assign pix_toggle = (next_state != ST_STANDBY);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      link.out_pixel_clock <= 1'b0;
    end else if (pix_toggle) begin
      link.out_pixel_clock <= ~link.out_pixel_clock;
    end else begin
      link.out_pixel_clock <= 1'b0; // RULE_02
    end
  end

endmodule : frame_sync_device

//--- hdl/frame_sync_host.sv
// Purpose: host controller end: broadcasts sync pulses, drives sleep_request
// Assumes: clk is the reference clock fed to every camera and runs free
// Notes: sleep edges are spaced so the clock is seen running around them
`timescale 1ns/10ps
module frame_sync_host
  import sync_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  sync_link_if.host        link,
  input  wire logic        start_req,
  input  wire logic        sleep_req,
  output logic             start_ready,
  output logic             frame_start,
  output logic [15:0]      frame_count
);

  localparam logic [3:0] PULSE_LOAD = 4'(SYNC_PULSE_CYCLES);
  localparam logic [3:0] GUARD_LOAD = 4'(CLK_GUARD_CYCLES);

  logic [3:0] pulse_cnt;
  logic [3:0] guard_cnt;
  logic       fv_meta;
  logic       fv_sync;
  logic       fv_prev;

  assign start_ready = (pulse_cnt == PULSE_CNT_RESET);

  // one broadcast pulse, held for the least width
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pulse_cnt <= PULSE_CNT_RESET;
    end else if (start_req && start_ready) begin
      pulse_cnt <= PULSE_LOAD; // RULE_06
    end else if (!start_ready) begin
      pulse_cnt <= pulse_cnt - 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      link.sync_pulse_in <= 1'b0; // RULE_13
    end else begin
      link.sync_pulse_in <= (start_req && start_ready) || (pulse_cnt > 4'h1); // RULE_06
    end
  end

  // the clock never stops here, so spacing edges covers both guard times
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      link.sleep_request <= 1'b0; // RULE_13
      guard_cnt          <= GUARD_CNT_RESET;
    end else if (guard_cnt != GUARD_CNT_RESET) begin
      guard_cnt <= guard_cnt - 4'h1; // RULE_04
    end else if (sleep_req != link.sleep_request) begin
      link.sleep_request <= sleep_req; // RULE_05
      guard_cnt          <= GUARD_LOAD;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fv_meta <= 1'b0;
      fv_sync <= 1'b0;
      fv_prev <= 1'b0;
    end else begin
      fv_meta <= link.out_frame_valid;
      fv_sync <= fv_meta;
      fv_prev <= fv_sync;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_start <= 1'b0;
      frame_count <= 16'h0000;
    end else begin
      frame_start <= fv_sync & ~fv_prev;
      if (fv_sync & ~fv_prev) begin
        frame_count <= frame_count + 16'h0001;
      end
    end
  end

endmodule : frame_sync_host

//--- verification/standby_and_frame_sync_trigger_tb.sv
// Purpose: host and camera ends joined, user sides driven
// Assumes: short line counts keep the run small
// Notes: a twin camera shares the pins to check alignment
`timescale 1ns/10ps
module standby_and_frame_sync_trigger_tb
  import sync_pkg::*;
;
  localparam int unsigned LC  = 8;
  localparam int unsigned ACT = 2;
  localparam int unsigned BLK = 1;
  logic        clk, rst_b, start_req, sleep_req, soft_reset_req, continuous_mode;
  logic [11:0] exposure_lines, sensor_delay_lines;
  logic        start_ready, frame_start, sensor_start_out, standby_active, busy, seen_start;
  logic [15:0] frame_count;
  int          n_mismatch, compares, n, k, lead, n_start;
  sync_link_if link ();
  sync_link_if twin ();
  assign twin.sleep_request = link.sleep_request;
  assign twin.sync_pulse_in = link.sync_pulse_in;

  frame_sync_host u_frame_sync_host (.clk(clk), .rst_b(rst_b), .link(link.host), .start_req(start_req),
    .sleep_req(sleep_req), .start_ready(start_ready), .frame_start(frame_start), .frame_count(frame_count));
  frame_sync_device #(.LINE_CYCLES(LC), .ACTIVE_LINES(ACT), .BLANK_LINES(BLK)) u_frame_sync_device (
    .clk(clk), .rst_b(rst_b), .link(link.dev), .soft_reset_req(soft_reset_req),
    .continuous_mode(continuous_mode), .exposure_lines(exposure_lines), .sensor_delay_lines(sensor_delay_lines),
    .sensor_start_out(sensor_start_out), .standby_active(standby_active), .busy(busy));
  frame_sync_device #(.LINE_CYCLES(LC), .ACTIVE_LINES(ACT), .BLANK_LINES(BLK)) u_frame_sync_device_twin (
    .clk(clk), .rst_b(rst_b), .link(twin.dev), .soft_reset_req(soft_reset_req),
    .continuous_mode(continuous_mode), .exposure_lines(exposure_lines), .sensor_delay_lines(sensor_delay_lines),
    .sensor_start_out(), .standby_active(), .busy());
  sync_link_monitor #(.LINE_CYCLES(LC), .ACTIVE_LINES(ACT), .BLANK_LINES(BLK)) u_sync_link_monitor (
    .clk(clk), .rst_b(rst_b), .sleep_request(link.sleep_request), .sync_pulse_in(link.sync_pulse_in),
    .out_frame_valid(link.out_frame_valid), .out_pixel_clock(link.out_pixel_clock));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic end_of_test();
    if (n_mismatch == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // every edge passes through here, so one-cycle host strobes are all seen
  task automatic tick();
    @(posedge clk);
    #10;
    if (frame_start === 1'b1) n_start++;
  endtask : tick

  task automatic pulse();
    k = 0;
    while (start_ready !== 1'b1 && k < 20) begin
      tick();
      k++;
    end
    if (k >= 20) begin
      check("ready wait", 16'h0001, 16'h0000);
      end_of_test();
    end
    start_req = 1'b1;
    tick();
    start_req = 1'b0;
    check("pulse taken", 16'({start_ready, link.sync_pulse_in}), 16'h0001);
  endtask : pulse

  // a missed deadline only ends the run when the event must come
  task automatic wait_fv(input logic lvl, input int bound, input bit must);
    n = 0;
    while (link.out_frame_valid !== lvl && n < bound) begin
      tick();
      n++;
      if (sensor_start_out === 1'b1) seen_start = 1'b1;
      check("twin fv", 16'(twin.out_frame_valid), 16'(link.out_frame_valid));
    end
    if (must && n >= bound) begin
      check("fv wait", 16'h0001, 16'h0000);
      end_of_test();
    end
  endtask : wait_fv

  task automatic wait_sb(input logic lvl);
    k = 0;
    while (standby_active !== lvl && k < 100) begin
      tick();
      k++;
    end
    if (k >= 100) begin
      check("standby wait", 16'h0001, 16'h0000);
      end_of_test();
    end
  endtask : wait_sb

  initial begin
    n_mismatch = 0;
    compares = 0;
    n_start = 0;
    rst_b = 1'b0;
    start_req = 1'b0;
    sleep_req = 1'b0;
    soft_reset_req = 1'b0;
    continuous_mode = 1'b0;
    exposure_lines = 12'h000;
    sensor_delay_lines = 12'h000;
    repeat (5) @(posedge clk);
    #10;
    rst_b = 1'b1;
    for (int i = 0; i < 2; i++) begin
      exposure_lines = (i == 0) ? 12'h002 : 12'h000;
      sensor_delay_lines = (i == 0) ? 12'h001 : 12'h000;
      lead = int'(TRIG_LEAD_LINES + exposure_lines + sensor_delay_lines) * LC;
      seen_start = 1'b0;
      pulse();
      wait_fv(1'b1, 400, 1'b1);
      check("lead", 16'(n >= lead && n <= lead + 8), 16'h0001);
      check("trigger", 16'(seen_start), 16'h0001);
      wait_fv(1'b0, 400, 1'b1);
      check("frame length", 16'(n), 16'(ACT * LC));
      wait_fv(1'b1, 200, 1'b0);
      check("one frame", 16'(n), 16'h00C8);
      check("frame count", frame_count, 16'(i + 1));
    end
    continuous_mode = 1'b1;
    pulse();
    wait_fv(1'b1, 400, 1'b1);
    wait_fv(1'b0, 400, 1'b1);
    wait_fv(1'b1, 400, 1'b1);
    check("blank", 16'(n), 16'(BLK * LC));
    // sleep asked mid-frame: the frame must finish first
    sleep_req = 1'b1;
    wait_sb(1'b1);
    check("standby time", 16'(k <= 2 * (ACT + BLK) * LC), 16'h0001);
    check("dark", 16'({link.out_frame_valid, link.out_pixel_clock}), 16'h0000);
    check("frame count", frame_count, 16'h0004);
    check("frame starts", 16'(n_start), 16'h0004);
    seen_start = 1'b0;
    pulse();
    wait_fv(1'b1, 30, 1'b0);
    check("refused", 16'(seen_start), 16'h0000);
    continuous_mode = 1'b0;
    sleep_req = 1'b0;
    wait_sb(1'b0);
    seen_start = 1'b0;
    pulse();
    wait_fv(1'b1, 10, 1'b0);
    check("woke", 16'({seen_start, busy}), 16'h0003);
    soft_reset_req = 1'b1;
    tick();
    soft_reset_req = 1'b0;
    check("soft reset", 16'({busy, sensor_start_out}), 16'h0000);
    wait_fv(1'b1, 200, 1'b0);
    check("no frame", 16'(n), 16'h00C8);
    // sleep from idle: one host edge, two synchroniser edges, one state edge
    sleep_req = 1'b1;
    wait_sb(1'b1);
    check("idle standby", 16'(k), 16'h0004);
    sleep_req = 1'b0;
    wait_sb(1'b0);
    check("clock guard", 16'(k >= int'(CLK_GUARD_CYCLES)), 16'h0001);
    check("idle wake", 16'({busy, standby_active}), 16'h0000);
    end_of_test();
  end
endmodule : standby_and_frame_sync_trigger_tb

//--- verification/sync_link_monitor.sv
// Purpose: pin checker for the sync link
// Assumes: one clock, async active-low reset
// Notes: standby shows on the pins as a held pixel clock
`timescale 1ns/10ps
module sync_link_monitor
  import sync_pkg::*;
#(
  parameter int unsigned LINE_CYCLES  = LINE_CYCLES_DEF,
  parameter int unsigned ACTIVE_LINES = ACTIVE_LINES_DEF,
  parameter int unsigned BLANK_LINES  = BLANK_LINES_DEF
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sleep_request,
  input wire logic sync_pulse_in,
  input wire logic out_frame_valid,
  input wire logic out_pixel_clock
);
  localparam int          STBY_MAX = 2 * int'((ACTIVE_LINES + BLANK_LINES) * LINE_CYCLES) + 8;
  localparam logic [11:0] LEAD_C   = 12'(TRIG_LEAD_LINES * LINE_CYCLES);
  localparam logic [11:0] FRAME_C  = 12'(ACTIVE_LINES * LINE_CYCLES);
  localparam logic [11:0] BLANK_C  = 12'(BLANK_LINES * LINE_CYCLES);
  logic        sleep_prev;
  logic        sync_prev;
  logic [3:0]  since_sleep;
  logic [11:0] since_sync;
  logic [11:0] high_run;
  logic [11:0] low_run;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // saturating, so a long quiet spell never wraps into a false short gap
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sleep_prev  <= 1'b0;
      since_sleep <= 4'hF;
    end else begin
      sleep_prev <= sleep_request;
      if (sleep_request != sleep_prev) since_sleep <= 4'h0;
      else if (since_sleep != 4'hF) since_sleep <= since_sleep + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_prev  <= 1'b0;
      since_sync <= 12'hFFF;
    end else begin
      sync_prev <= sync_pulse_in;
      if (sync_pulse_in && !sync_prev) since_sync <= 12'h000;
      else if (since_sync != 12'hFFF) since_sync <= since_sync + 12'h001;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      high_run <= 12'h000;
      low_run  <= 12'h000;
    end else if (out_frame_valid) begin
      high_run <= high_run + 12'h001;
      low_run  <= 12'h000;
    end else begin
      high_run <= 12'h000;
      if (low_run != 12'hFFF) low_run <= low_run + 12'h001;
    end
  end

  sequence dark_s;
    !out_pixel_clock [*2];
  endsequence

  sync_width_a: assert property ($rose(sync_pulse_in) |-> sync_pulse_in [*3] ##1 !sync_pulse_in)
    else $error("sync pulse width wrong");
  sleep_spacing_a: assert property ((sleep_request != sleep_prev) |-> since_sleep >= 4'hA)
    else $error("sleep edges too close");
  fv_lead_a: assert property ($rose(out_frame_valid) |-> since_sync >= LEAD_C)
    else $error("frame valid too early");
  pixclk_run_a: assert property (!sleep_request [*8] |-> out_pixel_clock != $past(out_pixel_clock))
    else $error("pixel clock stopped outside standby");
  standby_entry_a: assert property ($rose(sleep_request) |-> ##[1:STBY_MAX] dark_s)
    else $error("standby entry late");
  standby_dark_a: assert property (sleep_request && !out_pixel_clock && !$past(out_pixel_clock) |-> !out_frame_valid)
    else $error("frame valid in standby");
  frame_length_a: assert property ($fell(out_frame_valid) |-> high_run == FRAME_C)
    else $error("frame length wrong");
  blank_length_a: assert property ($rose(out_frame_valid) |-> low_run >= BLANK_C)
    else $error("blank too short");
endmodule : sync_link_monitor
